// ===== hw/pgsma_pkg.sv
// Constants for the gigabit status and MMD indirect access register bank
package pgsma_pkg;

	// Register offsets
	localparam logic [4:0]  ADDR_GIG_STATUS  = 5'h0A;
	localparam logic [4:0]  ADDR_MMD_CTRL    = 5'h0D;
	localparam logic [4:0]  ADDR_MMD_DATA    = 5'h0E;
	localparam logic [4:0]  ADDR_EXT_STATUS  = 5'h0F;
	localparam logic [4:0]  ADDR_FE_STATUS   = 5'h10;

	// Access control fields
	localparam int          MMD_FUNC_MSB     = 15;
	localparam int          MMD_FUNC_LSB     = 14;
	localparam int          MMD_DEV_MSB      = 4;
	localparam int          MMD_DEV_LSB      = 0;

	// Access function codes
	localparam logic [1:0]  FN_ADDRESS       = 2'h0;
	localparam logic [1:0]  FN_DATA          = 2'h1;
	localparam logic [1:0]  FN_DATA_INC_RW   = 2'h2;
	localparam logic [1:0]  FN_DATA_INC_WR   = 2'h3;

	// Reset values and idle counter ceiling
	localparam logic [1:0]  MMD_FUNC_RESET   = 2'h0;
	localparam logic [4:0]  MMD_DEV_RESET    = 5'h00;
	localparam logic [15:0] MMD_DATA_RESET   = 16'h0000;
	localparam logic [7:0]  IDLE_CNT_RESET   = 8'h00;
	localparam logic [7:0]  IDLE_CNT_MAX     = 8'hFF;
	localparam logic [15:0] RD_DATA_RESET    = 16'h0000;

	// Fixed extended ability word: 1000BASE-T full and half only
	localparam logic [15:0] EXT_STATUS_VALUE = 16'h3000;

	// Number of read-cleared fast Ethernet event flags
	localparam int          FE_EVENTS        = 6;

endpackage

// ===== hw/pgsma_regs.sv
// Gigabit status, extended ability, fast Ethernet status and MMD window registers
//
// Contract
// - Master/slave fault latches high until read
// - Bit 14 shows resolved master role
// - Bit 13 shows local receiver OK
// - Bit 12 shows remote receiver OK
// - Bits 11:10 show partner gigabit abilities
// - Idle error count, cleared on read
// - Function field selects address or data
// - Post-increment on reads+writes or writes only
// - Five-bit device address, read/write, reset zero
// - Address/data register: pointer or data
// - Extended status bits 13:12 read one
// - Extended status bits 15:14 read zero
// - Bit 15 live descrambler lock
// - Lock error flag cleared by read
// - Link-disconnect flag cleared by read
// - Bit 12 live link status
// - Receive/transmit error flags cleared by read
// - Delimiter error flags cleared by read
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module pgsma_regs
	import pgsma_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [4:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdData,
	input  wire logic        msFaultEvent,
	input  wire logic        msResolvedMaster,
	input  wire logic        localRxOk,
	input  wire logic        remoteRxOk,
	input  wire logic        partnerFullDuplex,
	input  wire logic        partnerHalfDuplex,
	input  wire logic        idleErrorEvent,
	input  wire logic        descramblerLocked,
	input  wire logic        lockErrorEvent,
	input  wire logic        linkDisconnectEvent,
	input  wire logic        linkUp,
	input  wire logic        rxErrorEvent,
	input  wire logic        txErrorEvent,
	input  wire logic        startDelimErrorEvent,
	input  wire logic        endDelimErrorEvent,
	input  wire logic [15:0] mmdReadData,
	output logic      [4:0]  mmdDevice,
	output logic      [15:0] mmdPointer,
	output logic             mmdWrite,
	output logic      [15:0] mmdWriteAddr,
	output logic      [15:0] mmdWriteData,
	output logic             mmdRead,
	output logic      [15:0] mmdReadAddr
);

	logic [1:0]            mmdFunction;
	logic                  msFault;
	logic [7:0]            idleCount;
	logic [FE_EVENTS-1:0]  feSticky;

	wire                   hitGig  = (regAddr == ADDR_GIG_STATUS);
	wire                   hitCtrl = (regAddr == ADDR_MMD_CTRL);
	wire                   hitData = (regAddr == ADDR_MMD_DATA);
	wire                   hitExt  = (regAddr == ADDR_EXT_STATUS);
	wire                   hitFe   = (regAddr == ADDR_FE_STATUS);
	wire                   rdGig   = regRead & hitGig;
	wire                   rdFe    = regRead & hitFe;
	wire                   wrCtrl  = regWrite & hitCtrl;

	wire                   isAddrFn  = (mmdFunction == FN_ADDRESS);
	wire                   incOnWr   = (mmdFunction == FN_DATA_INC_RW) |
	                                   (mmdFunction == FN_DATA_INC_WR);
	wire                   incOnRd   = (mmdFunction == FN_DATA_INC_RW);
	wire                   wrPointer = regWrite & hitData & isAddrFn;
	wire                   dataWr    = regWrite & hitData & ~isAddrFn;
	wire                   dataRd    = regRead & hitData & ~isAddrFn;

	wire                   bump = (dataWr & incOnWr) | (dataRd & incOnRd);
	wire [15:0]            next_mmdPointer = wrPointer ? regWrData :
	                                         bump ? mmdPointer + 16'h0001 : mmdPointer;

	wire                   next_msFault = msFaultEvent | (msFault & ~rdGig);

	wire [7:0]             idleInc = (idleCount == IDLE_CNT_MAX) ? idleCount :
	                                 idleCount + 8'h01;
	wire [7:0]             idleBase = rdGig ? IDLE_CNT_RESET : idleCount;
	wire [7:0]             next_idleCount = idleErrorEvent ?
	                                        (rdGig ? 8'h01 : idleInc) : idleBase;

	wire [FE_EVENTS-1:0]   feEvent = {lockErrorEvent, linkDisconnectEvent, rxErrorEvent,
	                                  txErrorEvent, startDelimErrorEvent, endDelimErrorEvent};
	wire [FE_EVENTS-1:0]   next_feSticky;

	// sticky per event, set beats clear
	genvar i;
	generate
		for (i = 0; i < FE_EVENTS; i++) begin : g_fe
			assign next_feSticky[i] = feEvent[i] | (feSticky[i] & ~rdFe);
		end
	endgenerate

	wire [15:0]            gigValue = {msFault, msResolvedMaster, localRxOk, remoteRxOk,
	                                   partnerFullDuplex, partnerHalfDuplex, 2'h0, idleCount};
	wire [15:0]            ctrlValue = {mmdFunction, 9'h000, mmdDevice};
	wire [15:0]            dataValue = isAddrFn ? mmdPointer : mmdReadData;
	wire [15:0]            feValue = {descramblerLocked, feSticky[5:4], linkUp,
	                                  feSticky[3:0], 8'h00};
	wire [15:0]            readMux = hitGig  ? gigValue :
	                                 hitCtrl ? ctrlValue :
	                                 hitData ? dataValue :
	                                 hitExt  ? EXT_STATUS_VALUE :
	                                 hitFe   ? feValue : 16'h0000;
	wire [15:0]            next_regRdData = regRead ? readMux : RD_DATA_RESET;

	// Read value captured before the clear lands on the same edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= RD_DATA_RESET;
			msFault   <= 1'b0;
			idleCount <= IDLE_CNT_RESET;
			feSticky  <= '0;
		end else begin
			regRdData <= next_regRdData;
			msFault   <= next_msFault;
			idleCount <= next_idleCount;
			feSticky  <= next_feSticky;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mmdFunction <= MMD_FUNC_RESET;
			mmdDevice   <= MMD_DEV_RESET;
		end else if (wrCtrl) begin
			mmdFunction <= regWrData[MMD_FUNC_MSB:MMD_FUNC_LSB];
			mmdDevice   <= regWrData[MMD_DEV_MSB:MMD_DEV_LSB];
		end
	end

	// Access address kept apart from pointer, which may already have moved
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mmdPointer   <= MMD_DATA_RESET;
			mmdWrite     <= 1'b0;
			mmdWriteAddr <= MMD_DATA_RESET;
			mmdWriteData <= MMD_DATA_RESET;
			mmdRead      <= 1'b0;
			mmdReadAddr  <= MMD_DATA_RESET;
		end else begin
			mmdPointer <= next_mmdPointer;
			mmdWrite   <= dataWr;
			mmdRead    <= dataRd;
			if (dataWr) begin
				mmdWriteAddr <= mmdPointer;
				mmdWriteData <= regWrData;
			end
			if (dataRd) begin
				mmdReadAddr <= mmdPointer;
			end
		end
	end

endmodule

// ===== verif/pgsma_monitor.sv
// Port assertions of the register bank
`timescale 1ns/1ns
module pgsma_monitor
	import pgsma_pkg::*;
(
	input wire logic        clock, rst_n, regWrite, regRead, msFaultEvent, idleErrorEvent,
	input wire logic        descramblerLocked, linkUp, mmdWrite, mmdRead,
	input wire logic [4:0]  regAddr, mmdDevice,
	input wire logic [15:0] regWrData, regRdData, mmdPointer, mmdWriteAddr, mmdWriteData
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rdGig = regRead && regAddr == ADDR_GIG_STATUS;
	wire logic rdFe = regRead && regAddr == ADDR_FE_STATUS;
	property p_ft; msFaultEvent ##1 rdGig |=> regRdData[15]; endproperty
	a_ft: assert property (p_ft) else $error("fault lost");
	property p_cg; rdGig && !msFaultEvent && !idleErrorEvent ##1 rdGig
		|=> {regRdData[15], regRdData[7:0]} == 9'h000; endproperty
	a_cg: assert property (p_cg) else $error("gig not cleared");
	property p_fl; rdFe |=> {regRdData[15], regRdData[12], regRdData[7:0]}
		== {$past(descramblerLocked), $past(linkUp), 8'h00}; endproperty
	a_fl: assert property (p_fl) else $error("fe live bits");
	property p_ex; regRead && regAddr == ADDR_EXT_STATUS |=> regRdData == 16'h3000; endproperty
	a_ex: assert property (p_ex) else $error("ext status");
	property p_rz; !$past(regRead) |-> regRdData == 16'h0000; endproperty
	a_rz: assert property (p_rz) else $error("idle read data");
	property p_dv; regWrite && regAddr == ADDR_MMD_CTRL |=> mmdDevice == 5'($past(regWrData));
	endproperty
	a_dv: assert property (p_dv) else $error("device field");
	property p_wr; mmdWrite |-> $past(regWrite) && $past(regAddr) == ADDR_MMD_DATA
		&& mmdWriteData == $past(regWrData) && mmdWriteAddr == $past(mmdPointer); endproperty
	a_wr: assert property (p_wr) else $error("window write");
	property p_rd; mmdRead |-> $past(regRead) && $past(regAddr) == ADDR_MMD_DATA; endproperty
	a_rd: assert property (p_rd) else $error("window read");
	c_gig: cover property (rdGig ##1 rdGig);
	c_wr: cover property (mmdWrite);
	c_rd: cover property (mmdRead);
endmodule

bind pgsma_regs pgsma_monitor i_pgsma_monitor (.*);

// ===== verif/pgsma_mmd_model.sv
// Manageable device store behind the window
`timescale 1ns/1ns
module pgsma_mmd_model (
	input  wire logic        clock,
	input  wire logic [4:0]  mmdDevice,
	input  wire logic [15:0] mmdPointer,
	input  wire logic        mmdWrite,
	input  wire logic [15:0] mmdWriteAddr,
	input  wire logic [15:0] mmdWriteData,
	output logic      [15:0] mmdReadData
);
	// Small store, upper address bits alias
	logic [15:0] mem [256];
	always @(posedge clock)
		if (mmdWrite) mem[{mmdDevice[3:0], mmdWriteAddr[3:0]}] <= mmdWriteData;
	assign mmdReadData = mem[{mmdDevice[3:0], mmdPointer[3:0]}];
endmodule

// ===== verif/tb.sv
// Self-checking bench of the register bank
`timescale 1ns/1ns
module tb
	import pgsma_pkg::*;
;
	logic        clock, rst_n, regWrite, regRead, mmdWrite, mmdRead, flt;
	logic [4:0]  regAddr, mmdDevice;
	logic [6:0]  lv;
	logic [7:0]  ev, e;
	logic [5:0]  fl;
	logic [15:0] regWrData, regRdData, mmdReadData, mmdPointer, mmdWriteAddr, mmdWriteData;
	logic [15:0] mmdReadAddr, v, p;
	int          bad_count, comparisons, cnt, cyc;
	pgsma_regs i_pgsma_regs (.*, .msFaultEvent(ev[0]), .idleErrorEvent(ev[1]),
		.endDelimErrorEvent(ev[2]), .startDelimErrorEvent(ev[3]), .txErrorEvent(ev[4]),
		.rxErrorEvent(ev[5]), .linkDisconnectEvent(ev[6]), .lockErrorEvent(ev[7]),
		.partnerHalfDuplex(lv[0]), .partnerFullDuplex(lv[1]), .remoteRxOk(lv[2]),
		.localRxOk(lv[3]), .msResolvedMaster(lv[4]), .descramblerLocked(lv[5]), .linkUp(lv[6]));
	pgsma_mmd_model i_pgsma_mmd_model (.*);
	always #5 clock = ~clock;
	always @(posedge clock) if (++cyc == 3000) begin
		bad_count++;
		test_done();
	end
	task automatic test_done();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, x);
		comparisons++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge clock) regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clock) {regRead, regAddr} <= {1'b1, a};
		@(posedge clock) regRead <= 1'b0;
		#1 v = regRdData;
	endtask
	task automatic rc(input string n, input logic [4:0] a, input logic [15:0] x);
		rd(a);
		chk(n, v, x);
	endtask
	initial begin
		void'($urandom(71637));
		{clock, rst_n, regWrite, regRead, regAddr, regWrData, lv, ev, flt, fl} = '0;
		{cnt, cyc, bad_count, comparisons} = '0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rc("ctrl", ADDR_MMD_CTRL, 16'h0000);
		rc("window", ADDR_MMD_DATA, 16'h0000);
		wr(ADDR_EXT_STATUS, 16'hFFFF);
		rc("ext", ADDR_EXT_STATUS, 16'h3000);
		rc("unmapped", 5'h03, 16'h0000);
		// Counter must stop at its top
		@(posedge clock) ev <= 8'h02;
		repeat (300) @(posedge clock);
		cnt = 255;
		for (int i = 0; i < 8; i++) begin
			repeat (4) begin
				@(posedge clock) e = 8'($urandom & $urandom);
				{ev, lv} <= {e, 7'($urandom)};
				flt |= e[0];
				cnt += (cnt < 255) ? e[1] : 0;
				fl |= e[7:2];
			end
			@(posedge clock) ev <= 8'h00;
			rc("gig", ADDR_GIG_STATUS, {flt, lv[4:0], 2'b00, 8'(cnt)});
			rc("fe", ADDR_FE_STATUS, {lv[5], fl[5:4], lv[6], fl[3:0], 8'h00});
			{flt, fl, cnt} = '0;
		end
		@(posedge clock) ev <= 8'h01;
		@(posedge clock) {ev, regRead, regAddr} <= {8'h00, 1'b1, ADDR_GIG_STATUS};
		repeat (2) @(posedge clock);
		regRead <= 1'b0;
		for (int f = 1; f < 4; f++) begin
			p = 16'($urandom);
			wr(ADDR_MMD_CTRL, 16'h3FE5);
			rc("ctrl", ADDR_MMD_CTRL, 16'h0005);
			wr(ADDR_MMD_DATA, p);
			rc("pointer", ADDR_MMD_DATA, p);
			wr(ADDR_MMD_CTRL, {2'(f), 14'h0005});
			wr(ADDR_MMD_DATA, ~p);
			rd(ADDR_MMD_DATA);
			if (f == 1) chk("data", v, ~p);
			wr(ADDR_MMD_CTRL, 16'h0005);
			rc("advance", ADDR_MMD_DATA, p + 16'(f > 1) + 16'(f == 2));
		end
		test_done();
	end
endmodule
